// File: pss_top.sv
// PHY status summary and interrupt logic with an APB register slave
//
// The implementer's own choice: register access over APB.
module pss_top #(
    parameter int EVENTS = 8
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LINK_UP,
    input wire logic SPEED_10,
    input wire logic FULL_DUPLEX,
    input wire logic LOOPBACK_ON,
    input wire logic AN_COMPLETE,
    input wire logic QUALITY_EVENT,
    input wire logic ENERGY_EVENT,
    input wire logic FALSE_CARRIER_HALF,
    input wire logic RX_ERROR_HALF,
    input wire logic SHARED_POWERDOWN_IRQ_PIN_I,
    output logic SHARED_POWERDOWN_IRQ_PIN_O,
    output logic SHARED_POWERDOWN_IRQ_PIN_OE_N,
    output logic POWER_DOWN_REQ
);

    generate
        if (EVENTS != pss_pkg::EVT_COUNT) begin : g_bad
            $error("pss_top: EVENTS must equal the eight event sources");
        end
    endgenerate

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [pss_pkg::CTL_W-1:0] control;
    logic [EVENTS-1:0] enables;
    logic [EVENTS-1:0] pending;
    logic [3:0] status;
    logic an_prev;
    logic irq_flag;
    logic pin_level;

    // ----------------------------------------
    // Status sampling and change detection
    // ----------------------------------------
    // The status bits are sampled every cycle; a read of the summary never
    // touches them, so link stays visible until the link itself drops.
    wire [3:0] next_status = {LOOPBACK_ON, FULL_DUPLEX, SPEED_10, LINK_UP};

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            status <= pss_pkg::STS_RESET;
            an_prev <= 1'b0;
        end else begin
            status <= next_status;
            an_prev <= AN_COMPLETE;
        end
    end

    wire link_change = LINK_UP != status[pss_pkg::STS_LINK];
    wire rate_change = SPEED_10 != status[pss_pkg::STS_SPEED];
    wire duplexity_change = FULL_DUPLEX != status[pss_pkg::STS_DUPLEX];
    wire negotiation_done = AN_COMPLETE & ~an_prev;

    wire [EVENTS-1:0] ev_set;
    assign ev_set[pss_pkg::EV_QUALITY] = QUALITY_EVENT;
    assign ev_set[pss_pkg::EV_ENERGY] = ENERGY_EVENT;
    assign ev_set[pss_pkg::EV_LINK_CHANGE] = link_change;
    assign ev_set[pss_pkg::EV_RATE_CHANGE] = rate_change;
    assign ev_set[pss_pkg::EV_DUPLEXITY_CHANGE] = duplexity_change;
    assign ev_set[pss_pkg::EV_NEGOTIATION_DONE] = negotiation_done;
    assign ev_set[pss_pkg::EV_FALSE_CARRIER_HALF] = FALSE_CARRIER_HALF;
    assign ev_set[pss_pkg::EV_RX_ERROR_HALF] = RX_ERROR_HALF;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire setup = PSEL & ~PENABLE;
    wire done = PSEL & PENABLE & PREADY;
    wire hit_status = PADDR == pss_pkg::ADDR_STATUS;
    wire hit_control = PADDR == pss_pkg::ADDR_CONTROL;
    wire hit_event = PADDR == pss_pkg::ADDR_EVENT;
    wire mapped = hit_status | hit_control | hit_event;
    wire wr_control = done & PWRITE & hit_control;
    wire wr_event = done & PWRITE & hit_event;
    wire rd_event = done & ~PWRITE & hit_event;

    wire [15:0] summary = {8'h00, irq_flag, 3'h0, status};
    wire [31:0] read_word = hit_status ? {16'h0000, summary}
        : hit_control ? {29'h0000000, control}
        : hit_event ? {16'h0000, pending, enables}
        : 32'h00000000;

    // Data is latched at the setup edge, so pending bits that rise after it
    // are not in the snapshot and are kept by the clear below.
    wire [31:0] next_prdata = (setup & ~PWRITE) ? read_word : 32'h00000000;
    wire next_pready = setup;
    wire next_pslverr = setup & ~mapped;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PRDATA <= next_prdata;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
        end
    end

    // ----------------------------------------
    // Control and enable registers
    // ----------------------------------------
    wire [pss_pkg::CTL_W-1:0] next_control = wr_control ? PWDATA[pss_pkg::CTL_W-1:0] : control;
    wire [EVENTS-1:0] next_enables = wr_event ? PWDATA[EVENTS-1:0] : enables;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            control <= pss_pkg::CTL_RESET;
            enables <= pss_pkg::EN_RESET;
        end else begin
            control <= next_control;
            enables <= next_enables;
        end
    end

    // ----------------------------------------
    // Pending bits, clear on read
    // ----------------------------------------
    // Only bits that were actually returned are cleared, and a new event
    // wins over the clear, so nothing is lost around a read.
    wire [EVENTS-1:0] clear_mask = rd_event ? PRDATA[pss_pkg::EVT_PEND_LSB +: EVENTS] : '0;

    genvar i;
    generate
        for (i = 0; i < EVENTS; i++) begin : g_pend
            wire next_pending = ev_set[i] | (pending[i] & ~clear_mask[i]);
            always_ff @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    pending[i] <= pss_pkg::PEND_RESET[i];
                end else begin
                    pending[i] <= next_pending;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Interrupt generation and shared pin
    // ----------------------------------------
    wire event_irq = control[pss_pkg::CTL_GLOBAL] & (|(pending & enables));
    wire irq_level = control[pss_pkg::CTL_TEST] | event_irq;
    wire next_irq_flag = irq_level;
    wire output_mode = control[pss_pkg::CTL_OE];
    wire next_pin_o = ~(output_mode & irq_level);
    wire next_pin_oe_n = ~output_mode;
    wire next_power_down = ~output_mode & ~pin_level;

    pss_pin_sync #(
        .WIDTH(1),
        .IDLE(1'b1)
    ) u_pin_sync (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .PIN(SHARED_POWERDOWN_IRQ_PIN_I),
        .LEVEL(pin_level)
    );

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            irq_flag <= 1'b0;
            SHARED_POWERDOWN_IRQ_PIN_O <= 1'b1;
            SHARED_POWERDOWN_IRQ_PIN_OE_N <= 1'b1;
            POWER_DOWN_REQ <= 1'b0;
        end else begin
            irq_flag <= next_irq_flag;
            SHARED_POWERDOWN_IRQ_PIN_O <= next_pin_o;
            SHARED_POWERDOWN_IRQ_PIN_OE_N <= next_pin_oe_n;
            POWER_DOWN_REQ <= next_power_down;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    AST_LINK_MIRROR: assert property (
        done & ~PWRITE & hit_status |-> PRDATA[pss_pkg::STS_LINK] == $past(LINK_UP, 2))
        else $error("link bit does not follow the link input");

    AST_LOOP_BIT: assert property (
        LOOPBACK_ON ##1 LOOPBACK_ON |-> summary[pss_pkg::STS_LOOP])
        else $error("loopback bit not shown");

    AST_DUPLEX_BIT: assert property (
        $changed(FULL_DUPLEX) |=> summary[pss_pkg::STS_DUPLEX] == $past(FULL_DUPLEX))
        else $error("duplex bit not shown");

    AST_SPEED_BIT: assert property (
        $rose(SPEED_10) |=> summary[pss_pkg::STS_SPEED] ##1 pending[pss_pkg::EV_RATE_CHANGE])
        else $error("speed bit or speed change event missing");

    AST_TEST_FORCE: assert property (
        control[pss_pkg::CTL_TEST] & output_mode |=> !SHARED_POWERDOWN_IRQ_PIN_O)
        else $error("test force does not drive interrupt");

    AST_GLOBAL_GATE: assert property (
        !control[pss_pkg::CTL_TEST] & !control[pss_pkg::CTL_GLOBAL] |=> !irq_flag)
        else $error("event interrupt without global enable");

    AST_OUTPUT_ROLE: assert property (
        output_mode |=> !SHARED_POWERDOWN_IRQ_PIN_OE_N && !POWER_DOWN_REQ)
        else $error("pin not driven while output enabled");

    AST_CONTROL_WRITE: assert property (
        wr_control |=> control == $past(PWDATA[2:0]))
        else $error("control write wrong");

    AST_SET_WINS: assert property (
        |ev_set |=> (pending & $past(ev_set)) == $past(ev_set))
        else $error("event lost");

    AST_READ_CLEARS: assert property (
        rd_event & ~|ev_set |=> (pending & $past(clear_mask)) == '0)
        else $error("pending bit not cleared by read");

    AST_SUMMARY_IRQ: assert property (
        irq_level |=> summary[pss_pkg::STS_IRQ])
        else $error("summary interrupt flag missing");

    AST_PIN_EVENT: assert property (
        output_mode & event_irq |=> !SHARED_POWERDOWN_IRQ_PIN_O)
        else $error("enabled event does not pull the pin low");

    AST_APB_ANSWER: assert property (
        setup |=> PREADY ##1 !PREADY)
        else $error("APB answer timing wrong");

    AST_CONTROL_UPPER: assert property (
        setup & ~PWRITE & hit_control |=> PRDATA[31:3] == 29'h0)
        else $error("control upper bits not zero");

    AST_READ_IDLE_ZERO: assert property (
        !PREADY |-> PRDATA == 32'h00000000)
        else $error("read data outside the answer cycle");

    AST_UNMAPPED_ERR: assert property (
        setup & ~mapped |=> PSLVERR && PRDATA == 32'h00000000)
        else $error("unmapped access not refused");

    // ----------------------------------------
    // Event capture and pin role checks
    // ----------------------------------------
    AST_QUALITY_SET: assert property (
        QUALITY_EVENT |=> pending[pss_pkg::EV_QUALITY])
        else $error("quality event not pending");

    AST_ENERGY_SET: assert property (
        ENERGY_EVENT |=> pending[pss_pkg::EV_ENERGY])
        else $error("energy event not pending");

    // Change detectors compare with the previous sample, which only means
    // something once the block has spent one edge out of reset.
    AST_LINK_SET: assert property (
        $past(RST_N) & $changed(LINK_UP) |=> pending[pss_pkg::EV_LINK_CHANGE])
        else $error("link change not pending");

    AST_RATE_SET: assert property (
        $past(RST_N) & $changed(SPEED_10) |=> pending[pss_pkg::EV_RATE_CHANGE])
        else $error("speed change not pending");

    AST_DUPLEXITY_SET: assert property (
        $past(RST_N) & $changed(FULL_DUPLEX) |=> pending[pss_pkg::EV_DUPLEXITY_CHANGE])
        else $error("duplex change not pending");

    AST_NEGOTIATION_SET: assert property (
        $past(RST_N) & $rose(AN_COMPLETE) |=> pending[pss_pkg::EV_NEGOTIATION_DONE])
        else $error("negotiation done not pending");

    AST_FALSE_CARRIER_SET: assert property (
        FALSE_CARRIER_HALF |=> pending[pss_pkg::EV_FALSE_CARRIER_HALF])
        else $error("false carrier half-full not pending");

    AST_RX_ERROR_SET: assert property (
        RX_ERROR_HALF |=> pending[pss_pkg::EV_RX_ERROR_HALF])
        else $error("receive error half-full not pending");

    AST_TEST_FLAG: assert property (
        control[pss_pkg::CTL_TEST] |=> irq_flag)
        else $error("test force not shown as interrupt");

    AST_INPUT_ROLE: assert property (
        !output_mode |=> SHARED_POWERDOWN_IRQ_PIN_OE_N && SHARED_POWERDOWN_IRQ_PIN_O)
        else $error("pin driven while in input role");

    AST_PIN_QUIET: assert property (
        output_mode & !irq_level |=> SHARED_POWERDOWN_IRQ_PIN_O)
        else $error("pin low without interrupt");

endmodule : pss_top

// File: pss_pkg.sv
// Constants shared by the PHY status and interrupt logic
// Summary of operation
// - Summary bit 3 reads 1 while loopback is on; read-only, resets to 0.
// - Summary bit 2 shows duplex, 1 full; valid only with link and negotiation done.
// - Summary bit 1 shows speed, 1 is 10 Mb/s, 0 is 100 Mb/s.
// - Summary bit 0 mirrors link status; reading the summary never clears it.
// - While the test bit 2 is set, interrupts are generated continuously.
// - Global enable bit 1 gates every event-based interrupt.
// - Output-enable bit 0 makes the shared pin an interrupt output, else power-down input.
// - Control bits 15 to 3 ignore writes, read zero; bits 2 to 0 reset to 0.
// - Link quality event sets pending bit 15, cleared on read; enable bit 7.
// - Energy detect event sets pending bit 14, cleared on read; enable bit 6.
// - Link change sets pending bit 13, cleared on read; enable bit 5.
// - Speed change sets pending bit 12, cleared on read; enable bit 4.
// - Duplex change sets pending bit 11, cleared on read; enable bit 3.
// - Negotiation completion sets pending bit 10, cleared on read; enable bit 2.
// - False carrier counter half-full sets pending bit 9, cleared on read; enable bit 1.
// - Receive error counter half-full sets pending bit 8, cleared on read; enable bit 0.
// - Summary bit 7 reads 1 while an interrupt is pending; event read clears it unless test bit 2 is set.
package pss_pkg;

    // ----------------------------------------
    // Register map (index times four is the byte address)
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] IDX_CONTROL = 12'h011;
    localparam logic [ADDR_W-1:0] IDX_EVENT = 12'h012;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = IDX_STATUS << 2;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = IDX_CONTROL << 2;
    localparam logic [ADDR_W-1:0] ADDR_EVENT = IDX_EVENT << 2;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int STS_LINK = 0;
    localparam int STS_SPEED = 1;
    localparam int STS_DUPLEX = 2;
    localparam int STS_LOOP = 3;
    localparam int STS_IRQ = 7;
    localparam int CTL_OE = 0;
    localparam int CTL_GLOBAL = 1;
    localparam int CTL_TEST = 2;
    localparam int CTL_W = 3;
    localparam int EVT_COUNT = 8;
    localparam int EVT_PEND_LSB = 8;
    // Event index: enable bit is the index, pending bit is index plus eight
    localparam int EV_RX_ERROR_HALF = 0;
    localparam int EV_FALSE_CARRIER_HALF = 1;
    localparam int EV_NEGOTIATION_DONE = 2;
    localparam int EV_DUPLEXITY_CHANGE = 3;
    localparam int EV_RATE_CHANGE = 4;
    localparam int EV_LINK_CHANGE = 5;
    localparam int EV_ENERGY = 6;
    localparam int EV_QUALITY = 7;

    // ----------------------------------------
    // Reset values and sync depth
    // ----------------------------------------
    localparam logic [CTL_W-1:0] CTL_RESET = 3'h0;
    localparam logic [EVT_COUNT-1:0] EN_RESET = 8'h00;
    localparam logic [EVT_COUNT-1:0] PEND_RESET = 8'h00;
    localparam logic [3:0] STS_RESET = 4'h0;
    localparam int SYNC_STAGES = 3;

endpackage : pss_pkg

// File: pss_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
module pss_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [WIDTH-1:0] PIN,
    output logic [WIDTH-1:0] LEVEL
);

    generate
        if (WIDTH < 1) begin : g_bad
            $error("pss_pin_sync: WIDTH must be at least 1");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic [pss_pkg::SYNC_STAGES-1:0] stage;
            wire agree = stage[1] == stage[2];
            // The first stage feeds only the second one
            always_ff @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    stage <= {pss_pkg::SYNC_STAGES{IDLE[i]}};
                end else begin
                    stage <= {stage[1:0], PIN[i]};
                end
            end
            always_ff @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    LEVEL[i] <= IDLE[i];
                end else if (agree) begin
                    LEVEL[i] <= stage[2];
                end
            end
        end
    endgenerate

endmodule : pss_pin_sync

// File: pss_host.sv
// Management host model: APB master that reaches the status and interrupt registers
module pss_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // No latency is assumed: the access phase lasts until pready is seen high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data lines change so stale data is never mistaken for valid
        pwdata <= ~wd;
    endtask : xfer
endmodule : pss_host

// File: phy_status_and_interrupt_logic_tb.sv
// Self-checking bench for the PHY status summary and interrupt logic
module phy_status_and_interrupt_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_ST = pss_pkg::ADDR_STATUS;
    localparam logic [11:0] A_CT = pss_pkg::ADDR_CONTROL;
    localparam logic [11:0] A_EV = pss_pkg::ADDR_EVENT;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic link_up, speed_10, full_duplex, loopback_on, an_complete;
    logic quality_event, energy_event, fc_half, rx_half, pd_drv;
    logic pin_o, pin_oe_n, pd_req;
    wire pin_lvl;
    int miscompares = 0;
    int check_count = 0;

    // The wire has a pull-up; the block drives it only while its enable is low
    assign pin_lvl = (pin_oe_n === 1'b0) ? pin_o : pd_drv;

    pss_top #(.EVENTS(8)) i_dut (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK_UP(link_up),
        .SPEED_10(speed_10), .FULL_DUPLEX(full_duplex), .LOOPBACK_ON(loopback_on),
        .AN_COMPLETE(an_complete), .QUALITY_EVENT(quality_event),
        .ENERGY_EVENT(energy_event), .FALSE_CARRIER_HALF(fc_half),
        .RX_ERROR_HALF(rx_half), .SHARED_POWERDOWN_IRQ_PIN_I(pin_lvl),
        .SHARED_POWERDOWN_IRQ_PIN_O(pin_o), .SHARED_POWERDOWN_IRQ_PIN_OE_N(pin_oe_n),
        .POWER_DOWN_REQ(pd_req));

    pss_host i_host (.clk(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ----------------------------------------
    // Shared checking tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic e;
        i_host.xfer(wr, a, wd, d, e);
        if (!wr) chk(d, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask : acc

    // Pin state as {output enable low-active, pin output, power-down request}
    task automatic pin(input logic [2:0] exp);
        @(posedge clock);
        chk({29'h0, pin_oe_n, pin_o, pd_req}, {29'h0, exp});
    endtask : pin

    task automatic fire(input int i);
        @(posedge clock);
        case (i)
            0: rx_half <= 1'b1;
            1: fc_half <= 1'b1;
            2: an_complete <= 1'b0;
            3: full_duplex <= ~full_duplex;
            4: speed_10 <= ~speed_10;
            5: link_up <= ~link_up;
            6: energy_event <= 1'b1;
            default: quality_event <= 1'b1;
        endcase
        @(posedge clock);
        {rx_half, fc_half, energy_event, quality_event} <= 4'h0;
        an_complete <= 1'b1;
    endtask : fire

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_reset();
        acc(1'b0, A_CT, 32'h0, 32'h0, 1'b0);
        acc(1'b0, A_EV, 32'h0, 32'h0, 1'b0);
        acc(1'b0, A_ST, 32'h0, 32'h0, 1'b0);
        pin(3'b110);
    endtask : s_reset

    task automatic s_control();
        acc(1'b1, A_CT, 32'hffff_ffff, 32'h0, 1'b0);
        acc(1'b0, A_CT, 32'h0, 32'h7, 1'b0);
        repeat (4) pin(3'b000);
        acc(1'b1, A_CT, 32'h3, 32'h0, 1'b0);
        repeat (2) @(posedge clock);
        pin(3'b010);
        acc(1'b1, A_CT, 32'h4, 32'h0, 1'b0);
        repeat (2) @(posedge clock);
        pin(3'b110);
        acc(1'b0, A_ST, 32'h0, 32'h80, 1'b0);
        acc(1'b1, A_CT, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 12'h000, 32'h0, 32'h0, 1'b1);
        acc(1'b1, A_ST, 32'hffff, 32'h0, 1'b0);
        acc(1'b0, A_ST, 32'h0, 32'h0, 1'b0);
    endtask : s_control

    task automatic s_power();
        pd_drv <= 1'b0;
        repeat (6) @(posedge clock);
        pin(3'b111);
        pd_drv <= 1'b1;
        repeat (6) @(posedge clock);
        pin(3'b110);
    endtask : s_power

    task automatic s_status();
        logic [3:0] v;
        for (int k = 0; k < 5; k++) begin
            v = (k == 4) ? 4'h1 : (4'h1 | (4'h1 << k)) ^ ((k == 3) ? 4'h6 : 4'h0);
            {loopback_on, full_duplex, speed_10, link_up} <= v;
            an_complete <= 1'b1;
            repeat (3) @(posedge clock);
            acc(1'b0, A_ST, 32'h0, {28'h0, v}, 1'b0);
            acc(1'b0, A_ST, 32'h0, {28'h0, v}, 1'b0);
        end
        // Link rose once, speed and duplex toggled, negotiation completed once
        acc(1'b0, A_EV, 32'h0, 32'h3c00, 1'b0);
    endtask : s_status

    task automatic s_events();
        logic [7:0] m;
        acc(1'b1, A_CT, 32'h3, 32'h0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            for (int p = 0; p < 2; p++) begin
                m = p ? 8'hff : 8'hff ^ 8'(1 << i);
                acc(1'b1, A_EV, {24'h0, m}, 32'h0, 1'b0);
                fire(i);
                repeat (3) @(posedge clock);
                pin(p ? 3'b000 : 3'b010);
                acc(1'b0, A_EV, 32'h0, {16'h0, 8'(1 << i), m}, 1'b0);
                acc(1'b0, A_EV, 32'h0, {16'h0, 8'h00, m}, 1'b0);
                pin(3'b010);
            end
        end
        acc(1'b1, A_CT, 32'h1, 32'h0, 1'b0);
        fire(7);
        repeat (3) @(posedge clock);
        pin(3'b010);
        acc(1'b0, A_ST, 32'h0, 32'h1, 1'b0);
        acc(1'b1, A_CT, 32'h3, 32'h0, 1'b0);
        repeat (2) @(posedge clock);
        pin(3'b000);
        acc(1'b0, A_ST, 32'h0, 32'h81, 1'b0);
        fork
            acc(1'b0, A_EV, 32'h0, 32'h80ff, 1'b0);
            begin
                repeat (2) @(posedge clock);
                quality_event <= 1'b1;
                @(posedge clock);
                quality_event <= 1'b0;
            end
        join
        acc(1'b0, A_EV, 32'h0, 32'h80ff, 1'b0);
    endtask : s_events

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        repeat (6000) @(posedge clock);
        miscompares++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        {link_up, speed_10, full_duplex, loopback_on, an_complete} = 5'h0;
        {quality_event, energy_event, fc_half, rx_half} = 4'h0;
        pd_drv = 1'b1;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        s_reset();
        s_control();
        s_power();
        s_status();
        s_events();
        test_done();
    end
endmodule : phy_status_and_interrupt_logic_tb
